// File: design/mbr_defines.vh
/*
 * constants for the read and exception unit of the serial slave:
 * function codes, exception and error codes, field limits, holding register offsets.
 * assumes it is included by its bare name from the design files only.
 */
// Functional notes
// R1: unsupported function code gives exception 01h
// R2: diagnosis sub-function not 00h gives 01h
// R3: start address above 1FFFh gives 02h
// R4: start plus count reaching 2000h gives 02h
// R5: register count zero or above 17 gives 03h
// R6: byte count not twice count gives 03h
// R7: wrong data length for function gives 03h
// R8: tool session running gives 04h, error 89h
// R9: internal busy flag gives 04h, error 8Ah
// R10: nonvolatile store alarm gives 04h, error 8Ah
// R11: write value out of range gives 04h/8Ch
// R12: command execution disabled gives 04h, error 8Dh
// R13: exception response carries one exception code byte
// R14: read function returns 16-bit holding registers
// R15: at most 16 registers per read
// R16: registers returned in ascending address order
// R17: master reads both halves in one query
// R18: query start address sent high byte first
// R19: query count high byte first, then check
// R20: check field sent low byte first
// R21: response echoes address, function, byte count
// R22: each register sent high byte first
// R23: exception function equals query function plus 80h
// R24: check is CRC-16, seed FFFFh, poly A001h
// R25: broadcast read gets no response
// R26: checks in fixed order, first failure reported
`ifndef MBR_DEFINES_VH
`define MBR_DEFINES_VH

`define MBR_FC_READ 8'h03
`define MBR_FC_WRITE1 8'h06
`define MBR_FC_DIAG 8'h08
`define MBR_FC_WRITEN 8'h10
`define MBR_FC_EXC_FLAG 8'h80
`define MBR_DIAG_SUB_ECHO 16'h0000
`define MBR_BCAST_ADDR 8'h00

`define MBR_EXC_FUNC 8'h01
`define MBR_EXC_ADDR 8'h02
`define MBR_EXC_DATA 8'h03
`define MBR_EXC_SLAVE 8'h04

`define MBR_ERR_NONE 8'h00
`define MBR_ERR_TOOL 8'h89
`define MBR_ERR_NVBUSY 8'h8a
`define MBR_ERR_RANGE 8'h8c
`define MBR_ERR_DISABLED 8'h8d

`define MBR_ADDR_MAX 16'h1fff
`define MBR_ADDR_LIMIT 17'h02000
`define MBR_CNT_LIMIT 16'h0011
`define MBR_READ_MAX 16
`define MBR_FIXED_DLEN 9'h004
`define MBR_MULTI_HDR_DLEN 9'h005
`define MBR_HDR_BYTES 9'h002
`define MBR_LEN_SAT 9'h1ff

`define MBR_CRC_SEED 16'hffff
`define MBR_CRC_POLY 16'ha001

`define MBR_REG_POS1_HI 16'h0402
`define MBR_REG_POS1_LO 16'h0403
`define MBR_REG_POS2_HI 16'h0404
`define MBR_REG_POS2_LO 16'h0405
`define MBR_POS_REGS 4
`define MBR_POS_RESET 16'h0000

`endif

// File: design/mbr_crc16.v
/*
 * crc-16 accumulator for the response byte stream, shifted right bit by bit.
 * assumes the caller clears it before the first byte and feeds each byte once.
 */
`include "mbr_defines.vh"

module mbr_crc16 (
    input wire ref_clk,
    input wire rst,
    input wire clr,
    input wire en,
    input wire [7:0] data,
    output reg [15:0] crc_q
);

reg [15:0] crc_d;
integer i;

////////////////////////////////////////////////////////////////////////////////
// one byte per enable, lsb first
always @* begin
    crc_d = crc_q ^ {8'h00, data};
    for (i = 0; i < 8; i = i + 1) begin
        if (crc_d[0]) begin
            crc_d = (crc_d >> 1) ^ `MBR_CRC_POLY; // R24
        end else begin
            crc_d = crc_d >> 1;
        end
    end
end

always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        crc_q <= `MBR_CRC_SEED;
    end else if (clr) begin
        crc_q <= `MBR_CRC_SEED; // R24
    end else if (en) begin
        crc_q <= crc_d;
    end
end

endmodule // mbr_crc16

// File: design/mbr_unit.v
/*
 * query checker and holding register read responder of the serial slave.
 * assumes the framing layer delivers crc-checked query bytes without the check
 * field, then an end pulse; all status inputs come from logic on ref_clk.
 */
`include "mbr_defines.vh"

module mbr_unit #(
    parameter READ_MAX = `MBR_READ_MAX
) (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] slave_addr,
    input wire [7:0] rx_data,
    input wire rx_valid,
    input wire rx_end,
    input wire tool_session_busy,
    input wire internal_busy_flag,
    input wire nonvolatile_store_alarm,
    input wire write_range_error,
    input wire command_disabled,
    input wire wr_en,
    input wire [15:0] wr_addr,
    input wire [15:0] wr_data,
    output wire [15:0] rd_addr,
    input wire [15:0] rd_data,
    output wire [7:0] tx_data,
    output wire tx_valid,
    output wire tx_last,
    input wire tx_ready,
    output wire exc_valid,
    output wire [7:0] exc_code,
    output wire [7:0] comm_err_code,
    output wire exec_valid,
    output wire [7:0] exec_func,
    output wire unit_busy
);

localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_CHECK = 3'd1;
localparam [2:0] S_HEAD = 3'd2;
localparam [2:0] S_DATA = 3'd3;
localparam [2:0] S_CRCL = 3'd4;
localparam [2:0] S_CRCH = 3'd5;
localparam [2:0] S_FIN = 3'd6;

localparam integer READ_MAX_I = READ_MAX;

////////////////////////////////////////////////////////////////////////////////
// state and storage
reg [2:0] state_q;
reg [7:0] qbyte_q [0:6];
reg [8:0] len_q;
reg [1:0] step_q;
reg [5:0] dcnt_q;
reg [15:0] raddr_q;
reg [7:0] lo_q;
reg [7:0] tx_data_q;
reg tx_valid_q;
reg tx_last_q;
reg is_exc_q;
reg [7:0] exc_code_q;
reg [7:0] err_code_q;
reg exc_valid_q;
reg exec_valid_q;
reg [7:0] exec_func_q;
reg [15:0] pos_q [0:`MBR_POS_REGS-1];
wire [15:0] crc_q;
reg crc_en;
reg [7:0] next_byte;

////////////////////////////////////////////////////////////////////////////////
// position holding registers, written by the neighbouring write logic
genvar g;
generate
    for (g = 0; g < `MBR_POS_REGS; g = g + 1) begin : g_pos
        always @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                pos_q[g] <= `MBR_POS_RESET;
            end else if (wr_en && wr_addr == `MBR_REG_POS1_HI + g) begin
                pos_q[g] <= wr_data;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// query capture
integer k;
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        len_q <= 9'h000;
        for (k = 0; k < 7; k = k + 1) begin
            qbyte_q[k] <= 8'h00;
        end
    end else if (state_q == S_IDLE) begin
        if (rx_end) begin
            len_q <= len_q;
        end else if (rx_valid) begin
            if (len_q < 9'd7) begin
                qbyte_q[len_q[2:0]] <= rx_data;
            end
            if (len_q != `MBR_LEN_SAT) begin
                len_q <= len_q + 9'h001;
            end
        end
    end else if (state_q == S_CHECK) begin
        len_q <= 9'h000;
    end
end

////////////////////////////////////////////////////////////////////////////////
// query checks
wire [7:0] q_addr = qbyte_q[0];
wire [7:0] q_func = qbyte_q[1];
wire [15:0] q_start = {qbyte_q[2], qbyte_q[3]}; // R18
wire [15:0] q_cnt = {qbyte_q[4], qbyte_q[5]}; // R19
wire [7:0] q_bc = qbyte_q[6];
wire [8:0] dlen = (len_q >= `MBR_HDR_BYTES) ? len_q - `MBR_HDR_BYTES : 9'h000;
wire is_read = q_func == `MBR_FC_READ;
wire is_diag = q_func == `MBR_FC_DIAG;
wire is_w1 = q_func == `MBR_FC_WRITE1;
wire is_wn = q_func == `MBR_FC_WRITEN;
wire is_write = is_w1 || is_wn;
wire has_cnt = is_read || is_wn;
wire bcast = q_addr == `MBR_BCAST_ADDR;
wire for_me = bcast || q_addr == slave_addr;
wire [16:0] addr_sum = {1'b0, q_start} + {1'b0, q_cnt};

wire func_bad = !(is_read || is_diag || is_write); // R1
wire sub_bad = is_diag && dlen >= 9'd2 && q_start != `MBR_DIAG_SUB_ECHO; // R2
wire addr_bad = (is_read || is_write) && dlen >= 9'd2 &&
    (q_start > `MBR_ADDR_MAX || // R3
     (has_cnt && dlen >= 9'd4 && addr_sum >= `MBR_ADDR_LIMIT)); // R4
wire len_bad = is_wn ? (dlen < `MBR_MULTI_HDR_DLEN || dlen != `MBR_MULTI_HDR_DLEN + {1'b0, q_bc})
    : (dlen != `MBR_FIXED_DLEN); // R7
wire cnt_bad = has_cnt && (q_cnt == 16'h0000 || q_cnt > `MBR_CNT_LIMIT || // R5
    (is_read && {16'h0000, q_cnt} > READ_MAX_I)); // R15
wire bc_bad = is_wn && {8'h00, q_bc} != {q_cnt[14:0], 1'b0}; // R6

reg chk_exc;
reg [7:0] chk_code;
reg [7:0] chk_err;
always @* begin
    chk_exc = 1'b1;
    chk_code = `MBR_EXC_SLAVE;
    chk_err = `MBR_ERR_NONE;
    if (func_bad || sub_bad) begin // R26
        chk_code = `MBR_EXC_FUNC; // R1 R2
    end else if (addr_bad) begin
        chk_code = `MBR_EXC_ADDR; // R3 R4
    end else if (len_bad || cnt_bad || bc_bad) begin
        chk_code = `MBR_EXC_DATA; // R5 R6 R7
    end else if (tool_session_busy) begin
        chk_err = `MBR_ERR_TOOL; // R8
    end else if (internal_busy_flag || nonvolatile_store_alarm) begin
        chk_err = `MBR_ERR_NVBUSY; // R9 R10
    end else if (is_write && write_range_error) begin
        chk_err = `MBR_ERR_RANGE; // R11
    end else if (command_disabled) begin
        chk_err = `MBR_ERR_DISABLED; // R12
    end else begin
        chk_exc = 1'b0;
        chk_code = 8'h00;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register word for the current read address
wire [15:0] pos_idx = raddr_q - `MBR_REG_POS1_HI;
wire pos_hit = raddr_q >= `MBR_REG_POS1_HI && raddr_q <= `MBR_REG_POS2_LO;
wire [15:0] cur_word = pos_hit ? pos_q[pos_idx[1:0]] : rd_data; // R14

////////////////////////////////////////////////////////////////////////////////
// response byte selection
wire can_load = !tx_valid_q || tx_ready;
always @* begin
    next_byte = 8'h00;
    crc_en = 1'b0;
    case (state_q)
        S_HEAD: begin
            crc_en = can_load;
            case (step_q)
                2'd0: begin
                    next_byte = q_addr; // R21
                end
                2'd1: begin
                    next_byte = is_exc_q ? (q_func | `MBR_FC_EXC_FLAG) : q_func; // R23
                end
                default: begin
                    next_byte = is_exc_q ? exc_code_q : {q_cnt[6:0], 1'b0}; // R13 R21
                end
            endcase
        end
        S_DATA: begin
            crc_en = can_load;
            next_byte = dcnt_q[0] ? lo_q : cur_word[15:8]; // R22
        end
        S_CRCL: begin
            next_byte = crc_q[7:0]; // R20
        end
        S_CRCH: begin
            next_byte = crc_q[15:8]; // R20
        end
        default: begin
            next_byte = 8'h00;
        end
    endcase
end

mbr_crc16 u_crc (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(state_q == S_CHECK),
    .en(crc_en),
    .data(next_byte),
    .crc_q(crc_q)
);

////////////////////////////////////////////////////////////////////////////////
// sequencer
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        state_q <= S_IDLE;
        step_q <= 2'd0;
        dcnt_q <= 6'd0;
        raddr_q <= 16'h0000;
        lo_q <= 8'h00;
        tx_data_q <= 8'h00;
        tx_valid_q <= 1'b0;
        tx_last_q <= 1'b0;
        is_exc_q <= 1'b0;
        exc_code_q <= 8'h00;
        err_code_q <= `MBR_ERR_NONE;
        exc_valid_q <= 1'b0;
        exec_valid_q <= 1'b0;
        exec_func_q <= 8'h00;
    end else begin
        exc_valid_q <= 1'b0;
        exec_valid_q <= 1'b0;
        if (tx_valid_q && tx_ready) begin
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
        end
        case (state_q)
            S_IDLE: begin
                if (rx_end) begin
                    state_q <= S_CHECK;
                end
            end
            S_CHECK: begin
                step_q <= 2'd0;
                dcnt_q <= 6'd0;
                raddr_q <= q_start; // R16
                is_exc_q <= chk_exc;
                exc_code_q <= chk_code;
                err_code_q <= chk_err;
                if (!for_me || len_q < `MBR_HDR_BYTES) begin
                    state_q <= S_IDLE;
                end else if (bcast) begin
                    exec_valid_q <= !chk_exc && is_write;
                    exec_func_q <= q_func;
                    state_q <= S_IDLE; // R25
                end else if (chk_exc) begin
                    exc_valid_q <= 1'b1;
                    state_q <= S_HEAD;
                end else if (is_read) begin
                    state_q <= S_HEAD;
                end else begin
                    exec_valid_q <= 1'b1;
                    exec_func_q <= q_func;
                    state_q <= S_IDLE;
                end
            end
            S_HEAD: begin
                if (can_load) begin
                    tx_data_q <= next_byte;
                    tx_valid_q <= 1'b1;
                    step_q <= step_q + 2'd1;
                    if (step_q == 2'd2) begin
                        state_q <= is_exc_q ? S_CRCL : S_DATA;
                    end
                end
            end
            S_DATA: begin
                if (can_load) begin
                    tx_data_q <= next_byte;
                    tx_valid_q <= 1'b1;
                    dcnt_q <= dcnt_q + 6'd1;
                    if (!dcnt_q[0]) begin
                        lo_q <= cur_word[7:0];
                    end else begin
                        raddr_q <= raddr_q + 16'h0001; // R16
                        if (dcnt_q[5:1] == q_cnt[4:0] - 5'd1) begin
                            state_q <= S_CRCL; // R15
                        end
                    end
                end
            end
            S_CRCL: begin
                if (can_load) begin
                    tx_data_q <= next_byte;
                    tx_valid_q <= 1'b1;
                    state_q <= S_CRCH;
                end
            end
            S_CRCH: begin
                if (can_load) begin
                    tx_data_q <= next_byte;
                    tx_valid_q <= 1'b1;
                    tx_last_q <= 1'b1;
                    state_q <= S_FIN;
                end
            end
            S_FIN: begin
                if (can_load) begin
                    state_q <= S_IDLE;
                end
            end
            default: begin
                state_q <= S_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs
assign rd_addr = raddr_q;
assign tx_data = tx_data_q;
assign tx_valid = tx_valid_q;
assign tx_last = tx_last_q;
assign exc_valid = exc_valid_q;
assign exc_code = exc_code_q;
assign comm_err_code = err_code_q;
assign exec_valid = exec_valid_q;
assign exec_func = exec_func_q;
assign unit_busy = state_q != S_IDLE;

endmodule // mbr_unit

// File: test/mbr_unit_assertions.sv
/* port checker of the read and exception unit.
   assumes a bind into mbr_unit, one clock domain. */
module mbr_unit_chk (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] slave_addr,
    input wire [7:0] tx_data,
    input wire tx_valid,
    input wire tx_last,
    input wire tx_ready,
    input wire exc_valid,
    input wire [7:0] exc_code,
    input wire [7:0] comm_err_code,
    input wire exec_valid,
    input wire [7:0] exec_func,
    input wire unit_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_first; exc_valid |=> tx_valid && tx_data == slave_addr; endproperty
    a_first: assert property (p_first) else $error("exception reply address wrong");
    property p_code; exc_valid |-> exc_code inside {8'h01, 8'h02, 8'h03, 8'h04}; endproperty
    a_code: assert property (p_code) else $error("exception code outside set");
    property p_err;
        exc_valid |-> (exc_code == 8'h04) ? comm_err_code inside {8'h89, 8'h8a, 8'h8c, 8'h8d} : comm_err_code == 8'h00;
    endproperty
    a_err: assert property (p_err) else $error("error code does not fit exception");
    property p_body; exc_valid ##1 tx_ready ##1 tx_ready |-> tx_data[7] ##1 tx_data == exc_code; endproperty
    a_body: assert property (p_body) else $error("exception function or code byte wrong");
    property p_len; exc_valid ##1 tx_ready [*5] |-> tx_valid && tx_last; endproperty
    a_len: assert property (p_len) else $error("exception reply length wrong");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last); endproperty
    a_hold: assert property (p_hold) else $error("byte changed before taken");
    property p_end; tx_valid && tx_ready && tx_last |=> !tx_valid; endproperty
    a_end: assert property (p_end) else $error("bytes after last byte");
    property p_exec; exec_valid |-> exec_func inside {8'h06, 8'h08, 8'h10} && !exc_valid ##1 !tx_valid [*3]; endproperty
    a_exec: assert property (p_exec) else $error("handed off query answered here");
    property p_idle; !unit_busy |-> !tx_valid && !exc_valid; endproperty
    a_idle: assert property (p_idle) else $error("output while idle");
endmodule // mbr_unit_chk

bind mbr_unit mbr_unit_chk u_chk (.ref_clk(ref_clk), .rst(rst), .slave_addr(slave_addr), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .exc_valid(exc_valid), .exc_code(exc_code),
    .comm_err_code(comm_err_code), .exec_valid(exec_valid), .exec_func(exec_func), .unit_busy(unit_busy));

// File: test/mbr_master_model.sv
/* serial master model: sends query bytes, takes reply bytes.
   assumes the bench loads queries by task; slow makes it stall. */
module mbr_master_model (
    input wire ref_clk,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_end,
    input wire [7:0] tx_data,
    input wire tx_valid,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow = 1'b0;
    logic [7:0] got [$];
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_end = 1'b0;
        tx_ready = 1'b1;
    end
    always @(negedge ref_clk) tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge ref_clk) if (tx_valid && tx_ready) got.push_back(tx_data);
    // bytes in frame order, words high byte first
    task automatic send(input logic [87:0] q, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            rx_data = q[87-8*i -: 8];
            rx_valid = 1'b1;
        end
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        rx_end = 1'b1;
        @(negedge ref_clk);
        rx_end = 1'b0;
    endtask
endmodule // mbr_master_model

// File: test/testbench.sv
/* self-checking bench of mbr_unit: table of queries, then reset cases.
   assumes mbr_master_model as far side; rd_data from a bench pattern. */
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [87:0] q; int n; logic [4:0] st; logic [7:0] ec; logic [7:0] ee;} mbr_row_t;
    logic ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, seen_exc = 1'b0, seen_exec = 1'b0;
    logic [15:0] wr_addr = 16'h0000, wr_data = 16'h0000;
    logic [4:0] st = 5'h00;
    logic [15:0] pos [4] = '{default: 16'h0000};
    wire [7:0] rx_data, tx_data, exc_code, comm_err_code, exec_func;
    wire rx_valid, rx_end, tx_valid, tx_last, tx_ready, exc_valid, exec_valid, unit_busy;
    wire [15:0] rd_addr;
    wire [15:0] rd_data = rd_addr ^ 16'h5a5a;
    int err_total = 0, samples_checked = 0;
    mbr_row_t rows [23];
    initial forever #25 ref_clk = ~ref_clk;
    mbr_unit u_dut (.ref_clk(ref_clk), .rst(rst), .slave_addr(8'h01), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_end(rx_end), .tool_session_busy(st[0]), .internal_busy_flag(st[1]), .nonvolatile_store_alarm(st[2]),
        .write_range_error(st[3]), .command_disabled(st[4]), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(tx_ready), .exc_valid(exc_valid), .exc_code(exc_code), .comm_err_code(comm_err_code),
        .exec_valid(exec_valid), .exec_func(exec_func), .unit_busy(unit_busy));
    mbr_master_model u_mst (.ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    always @(posedge ref_clk) begin
        if (exc_valid === 1'b1) seen_exc = 1'b1;
        if (exec_valid === 1'b1) seen_exec = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [87:0] rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c);
        return {8'h01, f, a, c, 40'h0};
    endfunction
    function automatic logic [15:0] crc(input logic [7:0] b [$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    function automatic logic [15:0] rv(input logic [15:0] r);
        return (r >= 16'h0402 && r <= 16'h0405) ? pos[r - 16'h0402] : r ^ 16'h5a5a;
    endfunction
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        wr_addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge ref_clk);
        wr_en = 1'b0;
        if (a >= 16'h0402 && a <= 16'h0405) pos[a - 16'h0402] = d;
    endtask
    task automatic run(input logic [87:0] q, input int n, input logic [7:0] ec, input logic [7:0] ee);
        logic [7:0] e [$];
        logic [15:0] c, v;
        int k;
        u_mst.got.delete();
        seen_exc = 1'b0;
        seen_exec = 1'b0;
        u_mst.send(q, n);
        k = 0;
        repeat (3) @(posedge ref_clk);
        while (unit_busy === 1'b1 && k < 400) begin
            @(posedge ref_clk);
            k++;
        end
        @(negedge ref_clk);
        `CHK(unit_busy, 1'b0)
        c = q[55:40];
        `CHK(exc_code, ec)
        `CHK(comm_err_code, (ec == 8'h00) ? 8'h00 : ee)
        if (ec != 8'h00) begin
            e = '{8'h01, q[79:72] | 8'h80, ec};
        end else if (q[87:72] == 16'h0103) begin
            e = '{8'h01, 8'h03, {c[6:0], 1'b0}};
            for (int i = 0; i < c; i++) begin
                v = rv(q[71:56] + 16'(i));
                e.push_back(v[15:8]);
                e.push_back(v[7:0]);
            end
        end
        if (e.size() > 0) begin
            c = crc(e);
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        `CHK(u_mst.got.size(), e.size())
        foreach (e[i]) if (i < u_mst.got.size()) `CHK(u_mst.got[i], e[i])
        `CHK(seen_exc, ec != 8'h00)
        `CHK(seen_exec, ec == 8'h00 && ee == 8'h01)
        if (seen_exec) `CHK(exec_func, q[79:72])
    endtask
    task results;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{rq(8'h04, 16'h0000, 16'h0001), 6, 5'h03, 8'h01, 8'h00},
            '{rq(8'h08, 16'h0001, 16'h1234), 6, 5'h00, 8'h01, 8'h00},
            '{rq(8'h08, 16'h0000, 16'h1234), 6, 5'h00, 8'h00, 8'h01},
            '{rq(8'h03, 16'h2000, 16'h0001), 6, 5'h00, 8'h02, 8'h00},
            '{rq(8'h03, 16'h1fff, 16'h0001), 6, 5'h01, 8'h02, 8'h00},
            '{rq(8'h03, 16'h1ffe, 16'h0002), 6, 5'h00, 8'h02, 8'h00},
            '{rq(8'h03, 16'h1ffe, 16'h0001), 6, 5'h00, 8'h00, 8'h00},
            '{rq(8'h03, 16'h0100, 16'h0000), 6, 5'h06, 8'h03, 8'h00},
            '{rq(8'h03, 16'h0100, 16'h0011), 6, 5'h00, 8'h03, 8'h00},
            '{rq(8'h03, 16'h0100, 16'h0012), 6, 5'h00, 8'h03, 8'h00},
            '{rq(8'h03, 16'h03f8, 16'h0010), 6, 5'h00, 8'h00, 8'h00},
            '{rq(8'h03, 16'h0402, 16'h0004), 5, 5'h00, 8'h03, 8'h00},
            '{88'h0110010000010400000000, 11, 5'h00, 8'h03, 8'h00},
            '{88'h0110010000010212340000, 9, 5'h00, 8'h00, 8'h01},
            '{rq(8'h06, 16'h0100, 16'h0005), 6, 5'h08, 8'h04, 8'h8c},
            '{rq(8'h03, 16'h0402, 16'h0002), 6, 5'h08, 8'h00, 8'h00},
            '{rq(8'h03, 16'h0402, 16'h0002), 6, 5'h01, 8'h04, 8'h89},
            '{rq(8'h03, 16'h0402, 16'h0002), 6, 5'h02, 8'h04, 8'h8a},
            '{rq(8'h08, 16'h0000, 16'h0000), 6, 5'h04, 8'h04, 8'h8a},
            '{rq(8'h03, 16'h0402, 16'h0002), 6, 5'h10, 8'h04, 8'h8d},
            '{88'h0003040200020000000000, 6, 5'h00, 8'h00, 8'h00},
            '{88'h0203040200020000000000, 6, 5'h00, 8'h00, 8'h00},
            '{88'h0006010000050000000000, 6, 5'h00, 8'h00, 8'h01}};
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        `CHK(tx_valid, 1'b0)
        `CHK(exc_code, 8'h00)
        run(rq(8'h03, 16'h0402, 16'h0004), 6, 8'h00, 8'h00);
        wr(16'h0402, 16'h0000);
        wr(16'h0403, 16'h2710);
        wr(16'h0404, 16'hffff);
        wr(16'h0405, 16'hd8f0);
        run(rq(8'h03, 16'h0402, 16'h0004), 6, 8'h00, 8'h00);
        u_mst.slow = 1'b1;
        run(rq(8'h03, 16'h0403, 16'h0003), 6, 8'h00, 8'h00);
        run(rq(8'h03, 16'h2000, 16'h0001), 6, 8'h02, 8'h00);
        u_mst.slow = 1'b0;
        foreach (rows[i]) begin
            st = rows[i].st;
            run(rows[i].q, rows[i].n, rows[i].ec, rows[i].ee);
            st = 5'h00;
        end
        u_mst.send(rq(8'h03, 16'h0402, 16'h0004), 6);
        repeat (6) @(negedge ref_clk);
        rst = 1'b1;
        @(negedge ref_clk);
        `CHK(tx_valid, 1'b0)
        `CHK(unit_busy, 1'b0)
        rst = 1'b0;
        pos = '{default: 16'h0000};
        run(rq(8'h03, 16'h0402, 16'h0004), 6, 8'h00, 8'h00);
        results();
    end
    initial begin
        #(20000 * 50);
        err_total++;
        results();
    end
endmodule // testbench
